// file: core/fpei_top.sv
`timescale 1ns/1ps
// Contract
// - high-voltage enable refused unless latches hold a valid array write
// - array writes load the latches only while latch-enable is set
// - with high voltage on, erase-select and latch-enable writes are ignored
// - boot-block protect makes programming writes inside the boot block ignored
// - erase covers the boot block only when boot-block protect is clear
// - in erase mode any valid address and any data arms the latches
// - stop or wait mode aborts programming or erasure at once
// - 250 ns recovery after stop; above 4 MHz needs wake-up delay bit
// - test functions reachable only while the special-mode line is high
// - special-mode low discards test writes and holds test register zero
// - special-mode high alone changes nothing until a test is invoked
// - high-voltage set with latch-enable clear performs no operation
// - array reads while high voltage is on do not return array data
// - once latched, further array writes ignored while latch-enable is set
module fpei_top
  import fpei_pkg::*;
#(
  parameter int AW        = 16,
  parameter int DW        = 16,
  parameter int BUS_HZ    = FPEI_CLK_HZ,
  parameter logic [AW-1:0] BOOT_LO = 16'hc000,
  parameter logic [AW-1:0] ARR_LO  = 16'h4000
) (
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          special_mode_line_i,
  input  wire logic          stop_mode_i,
  input  wire logic          wait_mode_i,
  input  wire logic [DW-1:0] array_rdata_i,
  output logic               high_voltage_enable_o,
  output logic               erase_select_o,
  output logic               boot_erase_o,
  output logic [AW-1:0]      prog_addr_o,
  output logic [DW-1:0]      prog_data_o,
  output logic [7:0]         program_page_select_o,
  output logic [7:0]         flash_test_register_o,
  output logic               flash_ready_o
);
  fpei_state_t   st_q;
  fpei_state_t   st_d;
  logic          hv_q;
  logic          hv_d;
  logic          lat_q;
  logic          lat_d;
  logic          erase_select_q;
  logic          erase_select_d;
  logic          boot_block_protect_q;
  logic          boot_block_protect_d;
  logic          wdly_q;
  logic          wdly_d;
  logic          abort_q;
  logic          abort_d;
  logic [7:0]    page_q;
  logic [7:0]    page_d;
  logic [7:0]    test_q;
  logic [7:0]    test_d;
  logic [AW-1:0] aaddr_q;
  logic [AW-1:0] aaddr_d;
  logic [31:0]   rdat_q;
  logic [31:0]   rdat_d;
  logic          ack_q;
  logic          ack_d;
  logic          lowpwr;
  logic          req;
  logic          wr;
  logic          rd;
  logic          loaded;
  logic          wake_busy;
  logic          wake_start;
  logic          stop_q;
  logic          stop_fall;
  logic          arr_wr;
  logic          arr_ok;
  logic          boot_hit;
  logic          load_ok;
  logic [AW-1:0] l_addr;
  logic [DW-1:0] l_data;

  function automatic logic in_boot(input logic [AW-1:0] a);
    return a >= BOOT_LO;
  endfunction

  function automatic logic in_array(input logic [AW-1:0] a);
    return a >= ARR_LO;
  endfunction

  assign lowpwr = stop_mode_i | wait_mode_i;
  assign req    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr     = req & wb_we_i;
  assign rd     = req & ~wb_we_i;
  assign arr_wr = wr & (wb_adr_i == FPEI_ADATA_OFS);
  assign arr_ok = in_array(aaddr_q);
  assign boot_hit = in_boot(aaddr_q) & boot_block_protect_q & ~erase_select_q;
  // erase arms on any valid address; program refuses the protected boot block
  assign load_ok = arr_wr & lat_q & arr_ok & ~boot_hit & ~hv_q;

  fpei_latch #(.AW(AW), .DW(DW)) u_latch (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .clear_i  (~lat_q),
    .load_i   (load_ok),
    .addr_i   (aaddr_q),
    .data_i   (wb_dat_i[DW-1:0]),
    .loaded_o (loaded),
    .addr_o   (l_addr),
    .data_o   (l_data)
  );

  // wake-up delay after stop; always armed on a slow bus, armed on a fast bus only with the delay bit set
  assign stop_fall = stop_q & ~stop_mode_i;
  // a fast bus without the delay bit gets no recovery time; software must avoid that
  assign wake_start = stop_fall & ((BUS_HZ <= FPEI_SLOW_BUS_HZ) | wdly_q);
  fpei_wake u_wake (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .start_i (wake_start),
    .busy_o  (wake_busy)
  );

  always_comb begin
    hv_d    = hv_q;
    lat_d   = lat_q;
    erase_select_d  = erase_select_q;
    boot_block_protect_d = boot_block_protect_q;
    wdly_d  = wdly_q;
    page_d  = page_q;
    aaddr_d = aaddr_q;
    test_d  = test_q;
    abort_d = abort_q;
    if (wr) begin
      case (wb_adr_i)
        FPEI_CTRL_OFS: begin
          if (!hv_q) begin
            lat_d   = wb_dat_i[FPEI_CTRL_LAT_BIT];
            erase_select_d  = wb_dat_i[FPEI_CTRL_ERASE_SELECT_BIT];
            boot_block_protect_d = wb_dat_i[FPEI_CTRL_BOOT_BLOCK_PROTECT_BIT];
          end
          wdly_d = wb_dat_i[FPEI_CTRL_WDLY_BIT];
          // set only from an armed state, cleared any time
          hv_d = wb_dat_i[FPEI_CTRL_HVEN_BIT] & lat_q & loaded & ~lowpwr
                 & (hv_q | wb_dat_i[FPEI_CTRL_LAT_BIT]);
          if (wb_dat_i[FPEI_STAT_ABORT_BIT + 8]) begin
            abort_d = 1'b0;
          end
        end
        FPEI_PAGE_OFS: begin
          page_d = wb_dat_i[7:0];
        end
        FPEI_ARRAY_OFS: begin
          aaddr_d = wb_dat_i[AW-1:0];
        end
        FPEI_TEST_OFS: begin
          if (special_mode_line_i) begin
            test_d = wb_dat_i[7:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (!special_mode_line_i) begin
      test_d = FPEI_TEST_RST;
    end
    if (lowpwr && hv_q) begin
      hv_d    = 1'b0;
      abort_d = 1'b1;
    end
  end

  always_comb begin
    case (st_q)
      FPEI_ST_IDLE: begin
        st_d = lat_q ? FPEI_ST_ARMED : FPEI_ST_IDLE;
      end
      FPEI_ST_ARMED: begin
        st_d = hv_q ? FPEI_ST_HV : (lat_q ? FPEI_ST_ARMED : FPEI_ST_IDLE);
      end
      FPEI_ST_HV: begin
        st_d = hv_q ? FPEI_ST_HV : FPEI_ST_ARMED;
      end
      FPEI_ST_WAKE: begin
        st_d = wake_busy ? FPEI_ST_WAKE : FPEI_ST_IDLE;
      end
      default: begin
        st_d = FPEI_ST_IDLE;
      end
    endcase
    if (wake_busy) begin
      st_d = FPEI_ST_WAKE;
    end
  end

  always_comb begin
    ack_d  = req;
    rdat_d = FPEI_UNMAPPED;
    if (rd) begin
      case (wb_adr_i)
        FPEI_CTRL_OFS: begin
          rdat_d[FPEI_CTRL_HVEN_BIT]  = hv_q;
          rdat_d[FPEI_CTRL_LAT_BIT]   = lat_q;
          rdat_d[FPEI_CTRL_ERASE_SELECT_BIT]  = erase_select_q;
          rdat_d[FPEI_CTRL_BOOT_BLOCK_PROTECT_BIT] = boot_block_protect_q;
          rdat_d[FPEI_CTRL_WDLY_BIT]  = wdly_q;
        end
        FPEI_STAT_OFS: begin
          rdat_d[FPEI_STAT_LOADED_BIT] = loaded;
          rdat_d[FPEI_STAT_READY_BIT]  = ~wake_busy;
          rdat_d[FPEI_STAT_ABORT_BIT]  = abort_q;
          rdat_d[FPEI_STAT_HV_BIT]     = hv_q;
          rdat_d[FPEI_STAT_ERASE_BIT]  = erase_select_q;
        end
        FPEI_LADDR_OFS: begin
          rdat_d[AW-1:0] = l_addr;
        end
        FPEI_LDATA_OFS: begin
          rdat_d[DW-1:0] = l_data;
        end
        FPEI_TEST_OFS: begin
          rdat_d[7:0] = test_q;
        end
        FPEI_PAGE_OFS: begin
          rdat_d[7:0] = page_q;
        end
        FPEI_ARRAY_OFS: begin
          rdat_d[AW-1:0] = aaddr_q;
        end
        FPEI_ADATA_OFS: begin
          // array data is withheld while high voltage is on
          if (!hv_q && !wake_busy) begin
            if (lat_q && !erase_select_q && loaded) begin
              rdat_d[DW-1:0] = l_data;
            end else begin
              rdat_d[DW-1:0] = array_rdata_i;
            end
          end
        end
        default: begin
          rdat_d = FPEI_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hv_q    <= 1'b0;
      lat_q   <= 1'b0;
      erase_select_q  <= 1'b0;
      boot_block_protect_q <= FPEI_CTRL_RST[FPEI_CTRL_BOOT_BLOCK_PROTECT_BIT];
      wdly_q  <= 1'b0;
      abort_q <= 1'b0;
      page_q  <= FPEI_PAGE_RST;
      test_q  <= FPEI_TEST_RST;
      aaddr_q <= '0;
      rdat_q  <= 32'h0000_0000;
      ack_q   <= 1'b0;
      st_q    <= FPEI_ST_IDLE;
      stop_q  <= 1'b0;
    end else begin
      hv_q    <= hv_d;
      lat_q   <= lat_d;
      erase_select_q  <= erase_select_d;
      boot_block_protect_q <= boot_block_protect_d;
      wdly_q  <= wdly_d;
      abort_q <= abort_d;
      page_q  <= page_d;
      test_q  <= test_d;
      aaddr_q <= aaddr_d;
      rdat_q  <= rdat_d;
      ack_q   <= ack_d;
      st_q    <= st_d;
      stop_q  <= stop_mode_i;
    end
  end

  assign wb_dat_o              = rdat_q;
  assign wb_ack_o              = ack_q;
  assign high_voltage_enable_o = hv_q;
  assign erase_select_o        = erase_select_q;
  assign boot_erase_o          = hv_q & erase_select_q & ~boot_block_protect_q;
  assign prog_addr_o           = l_addr;
  assign prog_data_o           = l_data;
  assign program_page_select_o = page_q;
  assign flash_test_register_o = test_q;
  assign flash_ready_o         = (st_q != FPEI_ST_WAKE);
endmodule

// file: core/fpei_pkg.sv
package fpei_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [7:0] FPEI_CTRL_OFS   = 8'h00;
  localparam logic [7:0] FPEI_STAT_OFS   = 8'h04;
  localparam logic [7:0] FPEI_LADDR_OFS  = 8'h08;
  localparam logic [7:0] FPEI_LDATA_OFS  = 8'h0c;
  localparam logic [7:0] FPEI_TEST_OFS   = 8'h10;
  localparam logic [7:0] FPEI_PAGE_OFS   = 8'h14;
  localparam logic [7:0] FPEI_ARRAY_OFS  = 8'h18;
  localparam logic [7:0] FPEI_ADATA_OFS  = 8'h1c;
  // control register bit positions
  localparam int FPEI_CTRL_HVEN_BIT  = 0;
  localparam int FPEI_CTRL_LAT_BIT   = 1;
  localparam int FPEI_CTRL_ERASE_SELECT_BIT  = 2;
  localparam int FPEI_CTRL_BOOT_BLOCK_PROTECT_BIT = 3;
  localparam int FPEI_CTRL_WDLY_BIT  = 4;
  // status register bit positions
  localparam int FPEI_STAT_LOADED_BIT = 0;
  localparam int FPEI_STAT_READY_BIT  = 1;
  localparam int FPEI_STAT_ABORT_BIT  = 2;
  localparam int FPEI_STAT_HV_BIT     = 3;
  localparam int FPEI_STAT_ERASE_BIT  = 4;
  // reset values
  localparam logic [4:0] FPEI_CTRL_RST = 5'h08;
  localparam logic [7:0] FPEI_TEST_RST = 8'h00;
  localparam logic [7:0] FPEI_PAGE_RST = 8'h00;
  // timing: wake-up recovery after stop
  localparam int FPEI_CLK_HZ         = 25000000;
  localparam int FPEI_WAKE_NS        = 250;
  localparam int FPEI_WAKE_CYC_RAW   = (FPEI_WAKE_NS * (FPEI_CLK_HZ / 1000000) + 999) / 1000;
  localparam int FPEI_WAKE_CYC       = (FPEI_WAKE_CYC_RAW < 1) ? 1 : FPEI_WAKE_CYC_RAW;
  localparam int FPEI_SLOW_BUS_HZ    = 4000000;
  localparam logic [31:0] FPEI_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {
    FPEI_ST_IDLE  = 2'b00,
    FPEI_ST_ARMED = 2'b01,
    FPEI_ST_HV    = 2'b10,
    FPEI_ST_WAKE  = 2'b11
  } fpei_state_t;
endpackage

// file: core/fpei_latch.sv
`timescale 1ns/1ps
module fpei_latch
  import fpei_pkg::*;
#(
  parameter int AW = 16,
  parameter int DW = 16
) (
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          clear_i,
  input  wire logic          load_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] data_i,
  output logic               loaded_o,
  output logic [AW-1:0]      addr_o,
  output logic [DW-1:0]      data_o
);
  logic          loaded_q, loaded_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] data_q, data_d;

  always_comb begin
    loaded_d = loaded_q;
    addr_d   = addr_q;
    data_d   = data_q;
    if (clear_i) begin
      loaded_d = 1'b0;
    end else if (load_i && !loaded_q) begin
      // first write only; later writes leave the latches alone
      loaded_d = 1'b1;
      addr_d   = addr_i;
      data_d   = data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      loaded_q <= 1'b0;
      addr_q   <= '0;
      data_q   <= '0;
    end else begin
      loaded_q <= loaded_d;
      addr_q   <= addr_d;
      data_q   <= data_d;
    end
  end

  assign loaded_o = loaded_q;
  assign addr_o   = addr_q;
  assign data_o   = data_q;
endmodule

// file: core/fpei_wake.sv
`timescale 1ns/1ps
module fpei_wake
  import fpei_pkg::*;
#(
  parameter int CYC = FPEI_WAKE_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic start_i,
  output logic      busy_o
);
  logic [7:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (start_i) begin
      cnt_d = 8'(CYC);
    end else if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy_o = (cnt_q != 8'h00);
endmodule

// file: test/fpei_props.sv
`timescale 1ns/1ps
module fpei_props
  import fpei_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        special_mode_line_i,
  input wire logic        stop_mode_i,
  input wire logic        wait_mode_i,
  input wire logic        high_voltage_enable_o,
  input wire logic        erase_select_o,
  input wire logic        boot_erase_o,
  input wire logic [15:0] prog_data_o,
  input wire logic [7:0]  flash_test_register_o
);
  logic req;
  // a request counts only at the edge that takes it
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_hv_set;
    $rose(high_voltage_enable_o) |-> $past(req && wb_we_i && wb_adr_i == FPEI_CTRL_OFS
      && wb_dat_i[1:0] == 2'b11 && !stop_mode_i && !wait_mode_i);
  endproperty
  a_hv_set: assert property (p_hv_set)
    else $error("voltage rose without a latch-enabled control write");
  property p_abort;
    (stop_mode_i || wait_mode_i) |=> !high_voltage_enable_o;
  endproperty
  a_abort: assert property (p_abort)
    else $error("voltage stayed on in a low-power mode");
  property p_erase_select_hold;
    $past(high_voltage_enable_o) |-> $stable(erase_select_o);
  endproperty
  a_erase_select_hold: assert property (p_erase_select_hold)
    else $error("erase select moved under high voltage");
  property p_test_zero;
    !special_mode_line_i ##1 !special_mode_line_i |-> flash_test_register_o == 8'h00;
  endproperty
  a_test_zero: assert property (p_test_zero)
    else $error("test register nonzero outside special mode");
  property p_boot;
    boot_erase_o |-> high_voltage_enable_o && erase_select_o;
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot erase outside an erase pulse");
  property p_hv_read;
    req && !wb_we_i && wb_adr_i == FPEI_ADATA_OFS && high_voltage_enable_o
      |=> wb_ack_o && wb_dat_o == 32'h0;
  endproperty
  a_hv_read: assert property (p_hv_read)
    else $error("array data returned under high voltage");
  property p_rst;
    $rose(rst_b_i) |-> !high_voltage_enable_o && !erase_select_o;
  endproperty
  a_rst: assert property (p_rst)
    else $error("control bits set after reset");
  property p_latch_src;
    $changed(prog_data_o) |-> $past(stop_mode_i || wait_mode_i) || $past(req && wb_we_i
      && (wb_adr_i == FPEI_ADATA_OFS || wb_adr_i == FPEI_CTRL_OFS));
  endproperty
  a_latch_src: assert property (p_latch_src)
    else $error("latch data changed without a cause");
endmodule

// file: test/fpei_cpu_model.sv
`timescale 1ns/1ps
module fpei_cpu_model
  import fpei_pkg::*;
#(
  parameter logic [15:0] ARR_WORD = 16'h5a5a
) (
  input  wire logic        clk_i,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  output logic [15:0]      array_rdata_o
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'hf;
    wb_dat_o = 32'h0;
  end
  // array cells read back one fixed word; no decode needed here
  assign array_rdata_o = ARR_WORD;
  // one register access per call keeps the steps apart
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_dat_o <= d;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

// file: test/fpei_tb_top.sv
`timescale 1ns/1ps
module fpei_tb_top
  import fpei_pkg::*;
;
  typedef struct packed {
    logic        we;
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [31:0] exp;
  } fpei_row_t;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        special_mode_line_i = 1'b0;
  logic        stop_mode_i = 1'b0;
  logic        wait_mode_i = 1'b0;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] array_rdata_i, prog_addr_o, prog_data_o;
  logic        high_voltage_enable_o, erase_select_o, boot_erase_o, flash_ready_o;
  logic [7:0]  program_page_select_o, flash_test_register_o;
  int          errors = 0;
  int          checks_done = 0;
  fpei_row_t   rows [8] = '{
    '{1'b0, FPEI_CTRL_OFS, 32'h0, 32'h08}, '{1'b0, FPEI_STAT_OFS, 32'h0, 32'h02},
    '{1'b1, FPEI_TEST_OFS, 32'h5a, 32'h0}, '{1'b0, FPEI_TEST_OFS, 32'h0, 32'h0},
    '{1'b1, FPEI_CTRL_OFS, 32'h09, 32'h0}, '{1'b0, FPEI_CTRL_OFS, 32'h0, 32'h08},
    '{1'b0, FPEI_ADATA_OFS, 32'h0, 32'h5a5a}, '{1'b0, 8'h20, 32'h0, 32'h0}};
  always #20 clk_i = ~clk_i;
  fpei_top uut (
    .clk_i                 (clk_i),
    .rst_b_i               (rst_b_i),
    .wb_cyc_i              (wb_cyc_i),
    .wb_stb_i              (wb_stb_i),
    .wb_we_i               (wb_we_i),
    .wb_adr_i              (wb_adr_i),
    .wb_sel_i              (wb_sel_i),
    .wb_dat_i              (wb_dat_i),
    .wb_dat_o              (wb_dat_o),
    .wb_ack_o              (wb_ack_o),
    .special_mode_line_i   (special_mode_line_i),
    .stop_mode_i           (stop_mode_i),
    .wait_mode_i           (wait_mode_i),
    .array_rdata_i         (array_rdata_i),
    .high_voltage_enable_o (high_voltage_enable_o),
    .erase_select_o        (erase_select_o),
    .boot_erase_o          (boot_erase_o),
    .prog_addr_o           (prog_addr_o),
    .prog_data_o           (prog_data_o),
    .program_page_select_o (program_page_select_o),
    .flash_test_register_o (flash_test_register_o),
    .flash_ready_o         (flash_ready_o)
  );
  fpei_cpu_model cpu (.clk_i(clk_i), .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o),
    .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i),
    .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i), .array_rdata_o(array_rdata_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    cpu.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].adr, rows[i].dat);
      else rd_chk(rows[i].adr, rows[i].exp);
    end
    // program one word, latch then voltage in separate writes
    wr(FPEI_PAGE_OFS, 32'h01);
    wr(FPEI_CTRL_OFS, 32'h0a);
    wr(FPEI_ARRAY_OFS, 32'h5000);
    wr(FPEI_ADATA_OFS, 32'h1234);
    rd_chk(FPEI_STAT_OFS, 32'h03);
    chk({16'h0, prog_addr_o}, 32'h5000);
    chk({24'h0, program_page_select_o}, 32'h01);
    wr(FPEI_ADATA_OFS, 32'h9999);
    rd_chk(FPEI_LDATA_OFS, 32'h1234);
    chk({16'h0, prog_data_o}, 32'h1234);
    rd_chk(FPEI_ADATA_OFS, 32'h1234);
    wr(FPEI_CTRL_OFS, 32'h0b);
    wr(FPEI_CTRL_OFS, 32'h05);
    rd_chk(FPEI_CTRL_OFS, 32'h0b);
    rd_chk(FPEI_ADATA_OFS, 32'h0);
    wr(FPEI_CTRL_OFS, 32'h0a);
    wr(FPEI_CTRL_OFS, 32'h0b);
    rd_chk(FPEI_CTRL_OFS, 32'h0b);
    wr(FPEI_CTRL_OFS, 32'h0a);
    // voltage and latch clear in one write must start nothing
    wr(FPEI_CTRL_OFS, 32'h09);
    rd_chk(FPEI_CTRL_OFS, 32'h08);
    wr(FPEI_CTRL_OFS, 32'h08);
    rd_chk(FPEI_STAT_OFS, 32'h02);
    // boot block stays shut while protected
    wr(FPEI_CTRL_OFS, 32'h0a);
    wr(FPEI_ARRAY_OFS, 32'hc010);
    wr(FPEI_ADATA_OFS, 32'h0001);
    rd_chk(FPEI_STAT_OFS, 32'h02);
    wr(FPEI_CTRL_OFS, 32'h0b);
    rd_chk(FPEI_CTRL_OFS, 32'h0a);
    // erase with boot block unprotected, any address arms it
    wr(FPEI_CTRL_OFS, 32'h06);
    wr(FPEI_ARRAY_OFS, 32'hc123);
    wr(FPEI_ADATA_OFS, 32'hffff);
    rd_chk(FPEI_STAT_OFS, 32'h13);
    chk({16'h0, prog_addr_o}, 32'hc123);
    wr(FPEI_CTRL_OFS, 32'h07);
    chk({31'h0, boot_erase_o}, 32'h1);
    chk({31'h0, erase_select_o}, 32'h1);
    wr(FPEI_CTRL_OFS, 32'h06);
    wr(FPEI_CTRL_OFS, 32'h07);
    stop_mode_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({31'h0, high_voltage_enable_o}, 32'h0);
    stop_mode_i <= 1'b0;
    cpu.xfer(1'b0, FPEI_STAT_OFS, 32'h0, q);
    chk(q & 32'h0c, 32'h04);
    wr(FPEI_CTRL_OFS, 32'h07);
    wait_mode_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({31'h0, high_voltage_enable_o}, 32'h0);
    wait_mode_i <= 1'b0;
    // delay bit on, abort flag cleared, voltage off before stop
    wr(FPEI_CTRL_OFS, 32'h410);
    stop_mode_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    stop_mode_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({31'h0, flash_ready_o}, 32'h0);
    cpu.xfer(1'b0, FPEI_STAT_OFS, 32'h0, q);
    chk(q & 32'h06, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({31'h0, flash_ready_o}, 32'h1);
    special_mode_line_i <= 1'b1;
    wr(FPEI_TEST_OFS, 32'h5a);
    rd_chk(FPEI_TEST_OFS, 32'h5a);
    chk({24'h0, flash_test_register_o}, 32'h5a);
    special_mode_line_i <= 1'b0;
    rd_chk(FPEI_TEST_OFS, 32'h0);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd_chk(FPEI_CTRL_OFS, 32'h08);
    final_report();
  end
endmodule
bind fpei_top fpei_props u_props (
  .clk_i                 (clk_i),
  .rst_b_i               (rst_b_i),
  .wb_cyc_i              (wb_cyc_i),
  .wb_stb_i              (wb_stb_i),
  .wb_we_i               (wb_we_i),
  .wb_adr_i              (wb_adr_i),
  .wb_dat_i              (wb_dat_i),
  .wb_dat_o              (wb_dat_o),
  .wb_ack_o              (wb_ack_o),
  .special_mode_line_i   (special_mode_line_i),
  .stop_mode_i           (stop_mode_i),
  .wait_mode_i           (wait_mode_i),
  .high_voltage_enable_o (high_voltage_enable_o),
  .erase_select_o        (erase_select_o),
  .boot_erase_o          (boot_erase_o),
  .prog_data_o           (prog_data_o),
  .flash_test_register_o (flash_test_register_o)
);
